// ==== sipc_top.sv ====
// sipc_top.sv: privilege check stage for decoded system instructions
`timescale 1ns/1ps
`default_nettype none
module sipc_top #(
   parameter bit FEATURE_PRESENT = 1'b1,         // restriction feature implemented
   parameter bit OS_ALIGN_ZERO = 1'b1,           // alignment-check set confined to zero
   parameter bit OS_INTR_FLAG_ZERO = 1'b0        // interrupt-flag set confined to zero
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // decoded instruction in
   input wire logic insn_valid_i,
   input wire sipc_pkg::sipc_op_t insn_op_i,
   input wire logic [sipc_pkg::SIPC_PL_W-1:0] current_privilege_level_i,
   input wire logic [sipc_pkg::SIPC_DATA_W-1:0] insn_operand_i,
   // checked instruction out
   output logic issue_valid_o,
   output sipc_pkg::sipc_op_t issue_op_o,
   output logic general_protection_fault_o,
   output logic [15:0] fault_code_o,
   // feature identification result
   output logic feat_valid_o,
   output logic [sipc_pkg::SIPC_DATA_W-1:0] third_result_register_o,
   // mode state
   output logic user_insn_restriction_mode_o,
   output logic [sipc_pkg::SIPC_DATA_W-1:0] control_register_four_o
);
   import sipc_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic issue;                 // instruction passes this cycle
      sipc_op_t op;                // passed instruction
      logic fault;                 // fault pulse
      logic [15:0] code;           // fault error code
      logic feat_valid;            // identification answer pulse
      logic [SIPC_DATA_W-1:0] feat; // third result register value
      logic [SIPC_DATA_W-1:0] cr4;  // control register four
   } sipc_state_t;

   sipc_state_t state_reg;       // registered state
   sipc_state_t state_next;      // next state
   sipc_priv_t fixed_priv;       // table class of the instruction
   logic need_zero;              // instruction needs level zero
   logic is_restricted_store;    // one of the five stores
   logic above_zero;             // caller is not most privileged
   logic cr4_bad;                // illegal write of bit eleven

   // ------------------------------------------------------------
   // class lookup
   // ------------------------------------------------------------
   sipc_class u_class (
      .op_i(insn_op_i),
      .priv_o(fixed_priv)
   );

   // ------------------------------------------------------------
   // decision
   // ------------------------------------------------------------
   // os-controlled class resolves from restriction bit and tie-offs
   always_comb begin
      is_restricted_store = (insn_op_i == SIPC_OP_GLOBAL_TABLE_STORE) ||
         (insn_op_i == SIPC_OP_INTR_TABLE_STORE) ||
         (insn_op_i == SIPC_OP_LOCAL_TABLE_STORE) ||
         (insn_op_i == SIPC_OP_MACHINE_STATUS_STORE) ||
         (insn_op_i == SIPC_OP_TASK_REG_STORE);
      above_zero = (current_privilege_level_i != SIPC_PL_ZERO);
      need_zero = 1'b0;
      case (fixed_priv)
         SIPC_PRIV_ZERO: need_zero = 1'b1;
         SIPC_PRIV_OS: begin
            // the os setting decides, not the table
            if (is_restricted_store) begin
               need_zero = state_reg.cr4[SIPC_RESTRICT_BIT];
            end else if (insn_op_i == SIPC_OP_ALIGN_CHECK_SET) begin
               need_zero = OS_ALIGN_ZERO;
            end else begin
               need_zero = OS_INTR_FLAG_ZERO;
            end
         end
         default: need_zero = 1'b0;
      endcase
      // a privileged write of bit eleven without the feature faults too
      cr4_bad = (insn_op_i == SIPC_OP_CTRL_REG_FOUR_WRITE) && !FEATURE_PRESENT &&
         insn_operand_i[SIPC_RESTRICT_BIT];
   end

   // next-state assembly; pulses drop unless refreshed
   always_comb begin
      state_next = state_reg;
      state_next.issue = 1'b0;
      state_next.fault = 1'b0;
      state_next.code = SIPC_FAULT_CODE;
      state_next.feat_valid = 1'b0;
      if (insn_valid_i) begin
         state_next.op = insn_op_i;
         if ((need_zero && above_zero) || cr4_bad) begin
            // suppressed instead of executed
            state_next.fault = 1'b1;
            state_next.code = SIPC_FAULT_CODE;
         end else begin
            state_next.issue = 1'b1;
            if (insn_op_i == SIPC_OP_CTRL_REG_FOUR_WRITE) begin
               state_next.cr4 = insn_operand_i;
            end
            if (insn_op_i == SIPC_OP_FEATURE_IDENT) begin
               state_next.feat_valid = 1'b1;
               state_next.feat = '0;
               if (insn_operand_i == SIPC_FEAT_LEAF) begin
                  state_next.feat[SIPC_FEAT_RESTRICT_BIT] = FEATURE_PRESENT;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // single state register; reset loads constants only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '{issue: 1'b0, op: SIPC_OP_NONE, fault: 1'b0, code: SIPC_FAULT_CODE,
            feat_valid: 1'b0, feat: '0, cr4: SIPC_CR4_RESET};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state flops
   assign issue_valid_o = state_reg.issue;
   assign issue_op_o = state_reg.op;
   assign general_protection_fault_o = state_reg.fault;
   assign fault_code_o = state_reg.code;
   assign feat_valid_o = state_reg.feat_valid;
   assign third_result_register_o = state_reg.feat;
   assign user_insn_restriction_mode_o = state_reg.cr4[SIPC_RESTRICT_BIT];
   assign control_register_four_o = state_reg.cr4;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence busy_set_user_s;
      insn_valid_i && insn_op_i == SIPC_OP_SHADOW_BUSY_SET && current_privilege_level_i != 2'h0;
   endsequence

   sequence fault_pulse_s;
      general_protection_fault_o && !issue_valid_o && fault_code_o == 16'h0000;
   endsequence

   busy_set_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
      busy_set_user_s |=> fault_pulse_s) else $error("busy-set above zero not faulted");
   shadow_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      insn_valid_i && insn_op_i == SIPC_OP_SHADOW_WRITE |=> issue_valid_o && !general_protection_fault_o)
      else $error("shadow write refused");
   user_shadow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      insn_valid_i && insn_op_i == SIPC_OP_USER_SHADOW_WRITE && current_privilege_level_i == 2'h3
      |=> fault_pulse_s) else $error("user shadow write above zero passed");
   vm_run_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
      insn_valid_i && insn_op_i == SIPC_OP_VM_RUN && current_privilege_level_i != 2'h0
      |=> general_protection_fault_o) else $error("vm run above zero passed");
   verify_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
      insn_valid_i && insn_op_i == SIPC_OP_SEG_READ_VERIFY |=> issue_valid_o)
      else $error("segment verify refused");
   feat_report_a: assert property (@(posedge clk_i) disable iff (rst_i)
      insn_valid_i && insn_op_i == SIPC_OP_FEATURE_IDENT && insn_operand_i == 32'h0000_0007
      |=> feat_valid_o && third_result_register_o[2] == FEATURE_PRESENT)
      else $error("feature bit wrong");
   mode_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
      insn_valid_i && insn_op_i == SIPC_OP_CTRL_REG_FOUR_WRITE && current_privilege_level_i == 2'h0
      && FEATURE_PRESENT |=> user_insn_restriction_mode_o == $past(insn_operand_i[11]))
      else $error("restriction bit not written");
   restricted_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
      user_insn_restriction_mode_o && insn_valid_i && insn_op_i == SIPC_OP_TASK_REG_STORE
      && current_privilege_level_i != 2'h0 |=> fault_pulse_s)
      else $error("restricted store above zero passed");
   store_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !user_insn_restriction_mode_o && insn_valid_i && insn_op_i == SIPC_OP_GLOBAL_TABLE_STORE
      |=> issue_valid_o) else $error("unrestricted store refused");
   exclusive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(issue_valid_o && general_protection_fault_o)) else $error("issue and fault together");
endmodule
`default_nettype wire

// ==== sipc_pkg.sv ====
// sipc_pkg.sv: constants and types of the system instruction privilege check
package sipc_pkg;
   // instruction classes presented by the decoder
   typedef enum logic [4:0] {
      SIPC_OP_NONE,
      SIPC_OP_SHADOW_BUSY_SET,
      SIPC_OP_SHADOW_RESTORE,
      SIPC_OP_SHADOW_SAVE_PREV,
      SIPC_OP_SHADOW_WRITE,
      SIPC_OP_USER_SHADOW_WRITE,
      SIPC_OP_GLOBAL_TABLE_STORE,
      SIPC_OP_INTR_TABLE_STORE,
      SIPC_OP_LOCAL_TABLE_STORE,
      SIPC_OP_TASK_REG_STORE,
      SIPC_OP_MACHINE_STATUS_STORE,
      SIPC_OP_ALIGN_CHECK_SET,
      SIPC_OP_INTR_FLAG_SET,
      SIPC_OP_GLOBAL_INTR_FLAG_SET,
      SIPC_OP_KERNEL_BASE_SWAP,
      SIPC_OP_VM_STATE_LOAD,
      SIPC_OP_VM_STATE_SAVE,
      SIPC_OP_HYPERVISOR_CALL,
      SIPC_OP_VM_RUN,
      SIPC_OP_CACHE_FLUSH_INVAL,
      SIPC_OP_CACHE_FLUSH_KEEP,
      SIPC_OP_MODEL_REG_WRITE,
      SIPC_OP_AUX_BASE_ONE_WRITE,
      SIPC_OP_AUX_BASE_TWO_WRITE,
      SIPC_OP_SEG_READ_VERIFY,
      SIPC_OP_SEG_WRITE_VERIFY,
      SIPC_OP_SECURE_LAUNCH,
      SIPC_OP_CTRL_REG_FOUR_WRITE,
      SIPC_OP_FEATURE_IDENT
   } sipc_op_t;

   // privilege class of one instruction
   typedef enum logic [1:0] {
      SIPC_PRIV_ANY,
      SIPC_PRIV_ZERO,
      SIPC_PRIV_OS
   } sipc_priv_t;

   localparam int SIPC_PL_W = 2;                    // privilege level width
   localparam logic [1:0] SIPC_PL_ZERO = 2'h0;      // most privileged level
   localparam int SIPC_DATA_W = 32;                 // result / operand width
   localparam int SIPC_RESTRICT_BIT = 11;           // restriction enable bit in ctrl reg four
   localparam int SIPC_FEAT_RESTRICT_BIT = 2;       // presence bit in third result register
   localparam logic [31:0] SIPC_FEAT_LEAF = 32'h0000_0007; // feature leaf seven
   localparam logic [15:0] SIPC_FAULT_CODE = 16'h0000;     // error code of the fault
   localparam logic [31:0] SIPC_CR4_RESET = 32'h0000_0000; // ctrl reg four reset value
endpackage

// ==== sipc_class.sv ====
// sipc_class.sv: combinational privilege class lookup per instruction
`timescale 1ns/1ps
`default_nettype none
module sipc_class (
   // instruction in
   input wire sipc_pkg::sipc_op_t op_i,
   // class out
   output sipc_pkg::sipc_priv_t priv_o
);
   import sipc_pkg::*;

   // fixed table of needed privilege; os-controlled ones resolved upstream
   always_comb begin
      case (op_i)
         SIPC_OP_SHADOW_BUSY_SET: priv_o = SIPC_PRIV_ZERO;
         SIPC_OP_SHADOW_RESTORE,
         SIPC_OP_SHADOW_SAVE_PREV: priv_o = SIPC_PRIV_ANY;
         SIPC_OP_SHADOW_WRITE: priv_o = SIPC_PRIV_ANY;
         SIPC_OP_USER_SHADOW_WRITE: priv_o = SIPC_PRIV_ZERO;
         SIPC_OP_GLOBAL_TABLE_STORE,
         SIPC_OP_INTR_TABLE_STORE,
         SIPC_OP_LOCAL_TABLE_STORE,
         SIPC_OP_TASK_REG_STORE,
         SIPC_OP_MACHINE_STATUS_STORE,
         SIPC_OP_ALIGN_CHECK_SET,
         SIPC_OP_INTR_FLAG_SET: priv_o = SIPC_PRIV_OS;
         SIPC_OP_GLOBAL_INTR_FLAG_SET: priv_o = SIPC_PRIV_ZERO;
         SIPC_OP_KERNEL_BASE_SWAP: priv_o = SIPC_PRIV_ZERO;
         SIPC_OP_VM_STATE_LOAD,
         SIPC_OP_VM_STATE_SAVE,
         SIPC_OP_HYPERVISOR_CALL,
         SIPC_OP_VM_RUN: priv_o = SIPC_PRIV_ZERO;
         SIPC_OP_CACHE_FLUSH_INVAL,
         SIPC_OP_CACHE_FLUSH_KEEP,
         SIPC_OP_MODEL_REG_WRITE: priv_o = SIPC_PRIV_ZERO;
         SIPC_OP_AUX_BASE_ONE_WRITE,
         SIPC_OP_AUX_BASE_TWO_WRITE: priv_o = SIPC_PRIV_ANY;
         SIPC_OP_SEG_READ_VERIFY,
         SIPC_OP_SEG_WRITE_VERIFY: priv_o = SIPC_PRIV_ANY;
         SIPC_OP_SECURE_LAUNCH: priv_o = SIPC_PRIV_ZERO;
         // control register writes are privileged moves
         SIPC_OP_CTRL_REG_FOUR_WRITE: priv_o = SIPC_PRIV_ZERO;
         default: priv_o = SIPC_PRIV_ANY;
      endcase
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
// tb.sv: self-checking bench for the system instruction privilege check
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sipc_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic insn_valid_i = 1'b0;
   sipc_op_t insn_op_i = SIPC_OP_NONE;
   logic [SIPC_PL_W-1:0] current_privilege_level_i = 2'h0;
   logic [SIPC_DATA_W-1:0] insn_operand_i = 32'h0000_0000;
   logic issue_valid_o;
   logic general_protection_fault_o;
   logic feat_valid_o;
   logic user_insn_restriction_mode_o;
   sipc_op_t issue_op_o;
   logic [15:0] fault_code_o;
   logic [31:0] third_result_register_o;
   logic [31:0] control_register_four_o;
   logic nf_fault; // second copy built without the restriction feature
   logic nf_mode;
   logic [31:0] nf_cr4;
   logic [31:0] nf_third;
   int fails = 0;
   int n_checks = 0;
   // 40 MHz core clock
   always #12.5 clk_i = ~clk_i;
   // ----------------------------------------
   // devices under test
   // ----------------------------------------
   sipc_top dut (.clk_i(clk_i), .rst_i(rst_i), .insn_valid_i(insn_valid_i),
      .insn_op_i(insn_op_i), .current_privilege_level_i(current_privilege_level_i),
      .insn_operand_i(insn_operand_i), .issue_valid_o(issue_valid_o), .issue_op_o(issue_op_o),
      .general_protection_fault_o(general_protection_fault_o), .fault_code_o(fault_code_o),
      .feat_valid_o(feat_valid_o), .third_result_register_o(third_result_register_o),
      .user_insn_restriction_mode_o(user_insn_restriction_mode_o),
      .control_register_four_o(control_register_four_o));
   // same stimulus; only its fault, mode, ctrl reg four and ident answers are judged
   sipc_top #(.FEATURE_PRESENT(1'b0)) dut_nofeat (.clk_i(clk_i), .rst_i(rst_i),
      .insn_valid_i(insn_valid_i), .insn_op_i(insn_op_i),
      .current_privilege_level_i(current_privilege_level_i), .insn_operand_i(insn_operand_i),
      .issue_valid_o(), .issue_op_o(), .general_protection_fault_o(nf_fault), .fault_code_o(),
      .feat_valid_o(), .third_result_register_o(nf_third),
      .user_insn_restriction_mode_o(nf_mode), .control_register_four_o(nf_cr4));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // expected level-zero requirement, worked out independently of the design
   function automatic logic needs_zero(input sipc_op_t op, input logic mode);
      case (op)
         SIPC_OP_SHADOW_BUSY_SET: return 1'b1;
         SIPC_OP_USER_SHADOW_WRITE: return 1'b1;
         SIPC_OP_GLOBAL_INTR_FLAG_SET: return 1'b1;
         SIPC_OP_KERNEL_BASE_SWAP: return 1'b1;
         SIPC_OP_VM_STATE_LOAD, SIPC_OP_VM_STATE_SAVE: return 1'b1;
         SIPC_OP_HYPERVISOR_CALL, SIPC_OP_VM_RUN: return 1'b1;
         SIPC_OP_CACHE_FLUSH_INVAL, SIPC_OP_CACHE_FLUSH_KEEP: return 1'b1;
         SIPC_OP_MODEL_REG_WRITE: return 1'b1;
         SIPC_OP_SECURE_LAUNCH: return 1'b1;
         SIPC_OP_CTRL_REG_FOUR_WRITE: return 1'b1; // control writes are level zero only
         SIPC_OP_ALIGN_CHECK_SET: return 1'b1;
         SIPC_OP_GLOBAL_TABLE_STORE, SIPC_OP_INTR_TABLE_STORE: return mode;
         SIPC_OP_LOCAL_TABLE_STORE, SIPC_OP_TASK_REG_STORE: return mode;
         SIPC_OP_MACHINE_STATUS_STORE: return mode;
         default: return 1'b0;
      endcase
   endfunction
   // one comparison; unknowns never match
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // present one instruction at the falling edge; it is taken at the next rising edge
   task automatic send(input sipc_op_t op, input logic [1:0] pl, input logic [31:0] val);
      insn_valid_i = 1'b1;
      insn_op_i = op;
      current_privilege_level_i = pl;
      insn_operand_i = val;
      @(negedge clk_i);
   endtask
   // exactly one of pass or fault, fault code zero
   task automatic judge(input sipc_op_t op, input logic bad);
      chk(general_protection_fault_o, bad);
      chk(issue_valid_o, !bad);
      chk(fault_code_o, SIPC_FAULT_CODE);
      chk(issue_op_o, op);
   endtask
   // drop the request; both pulses must fall after one cycle
   task automatic idle();
      insn_valid_i = 1'b0;
      @(negedge clk_i);
      chk({issue_valid_o, general_protection_fault_o}, 0);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // every class at every level, back to back, restriction off
   task automatic t_sweep();
      for (int pl = 0; pl < 4; pl++) begin
         for (int i = 0; i <= SIPC_OP_FEATURE_IDENT; i++) begin
            send(sipc_op_t'(i), pl[1:0], 32'h0000_0000);
            judge(sipc_op_t'(i), (pl != 0) && needs_zero(sipc_op_t'(i), 1'b0));
         end
      end
      idle();
   endtask
   // feature leaf seven reports the restriction bit; other leaves read zero
   task automatic t_ident();
      send(SIPC_OP_FEATURE_IDENT, 2'h3, SIPC_FEAT_LEAF);
      chk(feat_valid_o, 1);
      chk(third_result_register_o[SIPC_FEAT_RESTRICT_BIT], 1);
      chk(nf_third[SIPC_FEAT_RESTRICT_BIT], 0);
      send(SIPC_OP_FEATURE_IDENT, 2'h0, 32'h0000_0006);
      chk(third_result_register_o, 0);
      idle();
   endtask
   // enable restriction, then the five stores are level zero only
   task automatic t_restrict();
      logic [31:0] on_val;
      on_val = 32'h1 << SIPC_RESTRICT_BIT;
      send(SIPC_OP_CTRL_REG_FOUR_WRITE, 2'h2, on_val);
      judge(SIPC_OP_CTRL_REG_FOUR_WRITE, 1'b1);
      chk(user_insn_restriction_mode_o, 0);
      send(SIPC_OP_CTRL_REG_FOUR_WRITE, 2'h0, on_val);
      judge(SIPC_OP_CTRL_REG_FOUR_WRITE, 1'b0);
      chk(user_insn_restriction_mode_o, 1);
      chk(control_register_four_o, on_val);
      chk({nf_fault, nf_mode}, 2'b10);
      chk(nf_cr4, SIPC_CR4_RESET);
      for (int pl = 3; pl >= 0; pl--) begin
         for (int i = SIPC_OP_GLOBAL_TABLE_STORE; i <= SIPC_OP_MACHINE_STATUS_STORE; i++) begin
            send(sipc_op_t'(i), pl[1:0], 32'h0000_0000);
            judge(sipc_op_t'(i), pl != 0);
         end
      end
      // the os-set flag class stays open at any level
      send(SIPC_OP_INTR_FLAG_SET, 2'h3, 32'h0000_0000);
      judge(SIPC_OP_INTR_FLAG_SET, 1'b0);
      send(SIPC_OP_CTRL_REG_FOUR_WRITE, 2'h0, 32'h0000_0000);
      chk(user_insn_restriction_mode_o, 0);
      send(SIPC_OP_TASK_REG_STORE, 2'h3, 32'h0000_0000);
      judge(SIPC_OP_TASK_REG_STORE, 1'b0);
      idle();
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // main sequence: reset for 12 cycles, then the scenarios
   initial begin
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      chk({issue_valid_o, general_protection_fault_o, feat_valid_o}, 0);
      chk(control_register_four_o, SIPC_CR4_RESET);
      @(negedge clk_i);
      t_sweep();
      t_ident();
      t_restrict();
      results();
   end
   // watchdog: the scenarios need about 160 cycles
   initial begin
      repeat (2000) @(posedge clk_i);
      fails++;
      results();
   end
endmodule
`default_nettype wire
